//--- common/tbit_consts.svh
`ifndef TBIT_CONSTS_SVH
`define TBIT_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define TBIT_CTRL_IDX 6'h0a
`define TBIT_IST_IDX 6'h0b
`define TBIT_IMSK_IDX 6'h0c

// Control/status field positions.
`define TBIT_OVF_BIT 7
`define TBIT_IE_BIT 6
`define TBIT_SEL_HI 2
`define TBIT_SEL_LO 1
`define TBIT_CLR_BIT 0

// Interrupt status/mask field positions.
`define TBIT_EV_IV 0
`define TBIT_EV_STAB 1
`define TBIT_EV_W 2

// Reset values.
`define TBIT_SEL_RST 2'h0
`define TBIT_MSK_RST 2'h0

// Counter width.
`define TBIT_CW 21

// Overflow of counter bit k recurs every 2^(k+2) oscillator periods.
`define TBIT_IV_TAP0 11
`define TBIT_IV_TAP1 13
`define TBIT_IV_TAP2 16
`define TBIT_IV_TAP3 20
`define TBIT_ST_TAP0 2
`define TBIT_ST_TAP1 10
`define TBIT_ST_TAP2 14
`define TBIT_ST_TAP3 16
`define TBIT_WD_TAP 20
`define TBIT_BZ_LO 8
`define TBIT_BZ_HI 11

`endif

//--- common/tbit_pkg.sv
`default_nettype none

package tbit_pkg;

  typedef logic [20:0] tbit_cnt_t;

  // Interval select codes, shortest period first.
  typedef enum logic [1:0] {
    TBIT_IV_2P13 = 2'h0,
    TBIT_IV_2P15 = 2'h1,
    TBIT_IV_2P18 = 2'h2,
    TBIT_IV_2P22 = 2'h3
  } tbit_ivsel_e;

endpackage

`default_nettype wire

//--- common/tbit_tap_if.sv
`timescale 1ns/1ps
`default_nettype none

// Counter state and per-bit overflow strobes shared with the control logic.
interface tbit_tap_if;
  logic clr;
  logic run;
  tbit_pkg::tbit_cnt_t cnt;
  tbit_pkg::tbit_cnt_t ovf;

  modport ctr (input clr, input run, output cnt, output ovf);
  modport usr (output clr, output run, input cnt, input ovf);
endinterface

`default_nettype wire

//--- rtl/tbit_counter.sv
`timescale 1ns/1ps
`default_nettype none

`include "tbit_consts.svh"

module tbit_counter (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Counter side of the tap bundle.
  tbit_tap_if.ctr tap
);

  logic div_ff;
  logic adv;
  tbit_pkg::tbit_cnt_t cnt_ff;

  // Divide the oscillator by two; restart the phase on every clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 1'b0;
    end else if (tap.clr) begin
      div_ff <= 1'b0;
    end else if (tap.run) begin
      div_ff <= ~div_ff;
    end
  end

  // One count clock every two oscillator periods, none while stopped.
  assign adv = tap.run & div_ff;

  // Free-running up-counter; a clear beats an advance.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (tap.clr) begin
      cnt_ff <= '0;
    end else if (adv) begin
      cnt_ff <= cnt_ff + 21'h000001;
    end
  end

  assign tap.cnt = cnt_ff;

  // Bit k overflows when it and all lower bits are one at an advance.
  for (genvar k = 0; k < `TBIT_CW; k++) begin : g_ovf
    assign tap.ovf[k] = adv & (&cnt_ff[k:0]) & ~tap.clr;
  end

endmodule

`default_nettype wire

//--- rtl/tbit_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "tbit_consts.svh"

// Summary of operation
// - 21-bit counter advances at oscillator over two.
// - Counter halts while main oscillator stopped.
// - Clear on stop, sub-clock, power-on, software.
// - Clear bit writes zero to clear, reads one.
// - One of four bits drives interval interrupt.
// - Intervals 2^13, 2^15, 2^18, 2^22 oscillator periods.
// - Two-bit select field picks interval tap.
// - Flag in bit seven sets regardless enable.
// - Writing zero clears flag; one does nothing.
// - Request high while flag and enable set.
// - Unused bits ignore writes, read zero.
// - Stabilisation taps 2^4, 2^12, 2^16, 2^18.
// - Watchdog tick every 2^22 oscillator periods.
// - Buzzer taps from 2^10 to 2^13.
// - Clear with overflow together sets no flag.
// - Counter clear also clears watchdog when selected.
// - Enabling with flag set raises request immediately.
module tbit_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator status pin.
  input wire logic osc_running,
  // Clock controller and standby control.
  input wire logic main_stop_request,
  input wire logic subclock_select,
  input wire logic por_event,
  input wire logic por_clear_enable,
  input wire logic [1:0] stabilisation_wait_select,
  output logic stab_wait_done,
  // Watchdog.
  input wire logic wdt_src_timebase,
  output logic wdt_count_tick,
  output logic wdt_clear,
  // Buzzer clocks.
  output logic [3:0] buzzer_clk,
  // Interrupts.
  output logic timebase_interrupt_request,
  output logic irq
);

  tbit_tap_if tap ();

  logic osc_s1_ff;
  logic osc_s2_ff;
  logic osc_s3_ff;
  logic run_ff;
  logic ovf_flag_ff;
  logic irq_en_ff;
  logic [1:0] sel_ff;
  logic stab_done_ff;
  logic [`TBIT_EV_W-1:0] ist_ff;
  logic [`TBIT_EV_W-1:0] imsk_ff;
  logic [`TBIT_EV_W-1:0] ev;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic req;
  logic wr;
  logic rd_new;
  logic rd_done;
  logic hit_ctrl;
  logic hit_ist;
  logic hit_imsk;
  logic sw_clr;
  logic mode_clr;
  logic por_clr;
  logic iv_ovf;
  logic st_ovf;
  logic [7:0] ctrl_rd;
  logic [31:0] nxt_dat;

  // Counter core with divider and overflow strobes.
  tbit_counter u_counter (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tap(tap)
  );

  // The oscillator status arrives from outside the clock domain.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= osc_running;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  // Accept a new oscillator state once the last two stages agree.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 1'b0;
    end else if (osc_s2_ff == osc_s3_ff) begin
      run_ff <= osc_s3_ff;
    end
  end

  // Count only while the oscillator runs.
  assign tap.run = run_ff;

  // Bus request decode; the write acts at the edge that sees ack.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & ack_ff & wb_we_i;
  assign rd_new = req & ~ack_ff & ~wb_we_i;
  assign rd_done = req & ack_ff & ~wb_we_i;
  assign hit_ctrl = (wb_adr_i[7:2] == `TBIT_CTRL_IDX);
  assign hit_ist = (wb_adr_i[7:2] == `TBIT_IST_IDX);
  assign hit_imsk = (wb_adr_i[7:2] == `TBIT_IMSK_IDX);

  // Software clear: a zero written to the clear bit.
  assign sw_clr = wr & hit_ctrl & wb_sel_i[0]
                & ~wb_dat_i[`TBIT_CLR_BIT];

  // Held clear in main stop or sub-clock mode (select low).
  assign mode_clr = main_stop_request | ~subclock_select;

  // Optional clear on power-on reset.
  assign por_clr = por_event & por_clear_enable;

  // Any clear source resets the counter.
  assign tap.clr = sw_clr | mode_clr | por_clr;

  // Watchdog counter follows every clear when it counts from here.
  assign wdt_clear = tap.clr & wdt_src_timebase;

  // Interval tap chosen by the select field, codes ascending.
  always_comb begin
    case (tbit_pkg::tbit_ivsel_e'(sel_ff))
      tbit_pkg::TBIT_IV_2P13: iv_ovf = tap.ovf[`TBIT_IV_TAP0];
      tbit_pkg::TBIT_IV_2P15: iv_ovf = tap.ovf[`TBIT_IV_TAP1];
      tbit_pkg::TBIT_IV_2P18: iv_ovf = tap.ovf[`TBIT_IV_TAP2];
      tbit_pkg::TBIT_IV_2P22: iv_ovf = tap.ovf[`TBIT_IV_TAP3];
      default: iv_ovf = 1'b0;
    endcase
  end

  // Stabilisation wait tap chosen by the clock controller.
  always_comb begin
    case (stabilisation_wait_select)
      2'h0: st_ovf = tap.ovf[`TBIT_ST_TAP0];
      2'h1: st_ovf = tap.ovf[`TBIT_ST_TAP1];
      2'h2: st_ovf = tap.ovf[`TBIT_ST_TAP2];
      2'h3: st_ovf = tap.ovf[`TBIT_ST_TAP3];
      default: st_ovf = 1'b0;
    endcase
  end

  // Overflow flag: set wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_flag_ff <= 1'b0;
    end else if (iv_ovf) begin
      ovf_flag_ff <= 1'b1;
    end else if (wr & hit_ctrl & wb_sel_i[0]
                 & ~wb_dat_i[`TBIT_OVF_BIT]) begin
      ovf_flag_ff <= 1'b0;
    end
  end

  // Interrupt enable and interval select; unused bits are dropped.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_ff <= 1'b0;
      sel_ff <= `TBIT_SEL_RST;
    end else if (wr & hit_ctrl & wb_sel_i[0]) begin
      irq_en_ff <= wb_dat_i[`TBIT_IE_BIT];
      sel_ff <= wb_dat_i[`TBIT_SEL_HI:`TBIT_SEL_LO];
    end
  end

  // Request follows flag and enable with no extra overflow needed.
  assign timebase_interrupt_request =
    ovf_flag_ff & irq_en_ff;

  // Stabilisation wait elapsed; restarts with every counter clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stab_done_ff <= 1'b0;
    end else if (tap.clr) begin
      stab_done_ff <= 1'b0;
    end else if (st_ovf) begin
      stab_done_ff <= 1'b1;
    end
  end

  assign stab_wait_done = stab_done_ff;

  // Watchdog count tick from the top counter bit.
  assign wdt_count_tick = tap.ovf[`TBIT_WD_TAP];

  // Buzzer clocks straight from counter flops.
  assign buzzer_clk = tap.cnt[`TBIT_BZ_HI:`TBIT_BZ_LO];

  // Events that feed the sticky interrupt status.
  assign ev[`TBIT_EV_IV] = iv_ovf;
  assign ev[`TBIT_EV_STAB] = st_ovf & ~stab_done_ff;

  // Sticky status, cleared by a read; a new event beats the clear.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ist_ff <= '0;
    end else if (rd_done & hit_ist) begin
      ist_ff <= ev;
    end else begin
      ist_ff <= ist_ff | ev;
    end
  end

  // Interrupt mask, same layout as the status.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      imsk_ff <= `TBIT_MSK_RST;
    end else if (wr & hit_imsk & wb_sel_i[0]) begin
      imsk_ff <= wb_dat_i[`TBIT_EV_W-1:0];
    end
  end

  // One level interrupt for any unmasked status bit.
  assign irq = |(ist_ff & imsk_ff);

  // Control register read image; clear bit always reads one.
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`TBIT_OVF_BIT] = ovf_flag_ff;
    ctrl_rd[`TBIT_IE_BIT] = irq_en_ff;
    ctrl_rd[`TBIT_SEL_HI:`TBIT_SEL_LO] = sel_ff;
    ctrl_rd[`TBIT_CLR_BIT] = 1'b1;
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    nxt_dat = 32'h00000000;
    if (hit_ctrl) begin
      nxt_dat[7:0] = ctrl_rd;
    end else if (hit_ist) begin
      nxt_dat[`TBIT_EV_W-1:0] = ist_ff;
    end else if (hit_imsk) begin
      nxt_dat[`TBIT_EV_W-1:0] = imsk_ff;
    end
  end

  // Single-cycle acknowledge, dropped the cycle after it is given.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read data captured as the acknowledge is raised.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dat_ff <= 32'h00000000;
    end else if (rd_new) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule

`default_nettype wire

//--- dv/tbit_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module tbit_top_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Mode, watchdog, buzzer and interrupt pins.
  input wire logic main_stop_request,
  input wire logic wdt_src_timebase,
  input wire logic wdt_count_tick,
  input wire logic wdt_clear,
  input wire logic [3:0] buzzer_clk,
  input wire logic timebase_interrupt_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // A request is taken, and a control read is answered.
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctrl_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h28;
  endsequence

  a_ack_next: assert property (s_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_clr_reads_one: assert property (
    s_ctrl_rd |-> wb_dat_o[0] && wb_dat_o[5:3] == 3'h0)
    else $error("clear bit or unused bits read wrong");
  a_irq_matches: assert property (
    s_ctrl_rd |-> $past(timebase_interrupt_request)
      == (wb_dat_o[7] && wb_dat_o[6]))
    else $error("request differs from flag and enable");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 0)
    else $error("upper read bits not zero");
  a_stop_clears: assert property (
    main_stop_request |=> buzzer_clk == 4'h0)
    else $error("counter not cleared in main stop");
  a_stop_no_tick: assert property (
    main_stop_request |-> !wdt_count_tick)
    else $error("tick during counter clear");
  a_wdt_gate: assert property (!wdt_src_timebase |-> !wdt_clear)
    else $error("watchdog cleared while not selected");
  a_wdt_follow: assert property (
    main_stop_request && wdt_src_timebase |-> wdt_clear)
    else $error("watchdog not cleared with counter");
  a_tick_single: assert property (
    wdt_count_tick |=> !wdt_count_tick)
    else $error("watchdog tick wider than one cycle");
endmodule

bind tbit_top tbit_top_props i_tbit_top_props (.*);

`default_nettype wire

//--- dv/tbit_clk_model.sv
`timescale 1ns/1ps
`default_nettype none

module tbit_clk_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Mode request: bit 0 main stop, bit 1 sub-clock.
  input wire logic [1:0] mode_cmd,
  // Clock controller outputs.
  output logic osc_running,
  output logic main_stop_request,
  output logic subclock_select
);
  // The oscillator restarts only after no mode holds it stopped.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_running <= 1'b1;
      main_stop_request <= 1'b0;
      subclock_select <= 1'b1;
    end else begin
      main_stop_request <= mode_cmd[0];
      subclock_select <= !mode_cmd[1];
      osc_running <= mode_cmd == 2'h0 && !main_stop_request && subclock_select;
    end
  end
endmodule

`default_nettype wire

//--- dv/tbit_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tbit_top_tb_top;
  logic ref_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, por_event = 1'b0, por_clear_enable = 1'b1;
  logic wdt_src_timebase = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [1:0] stabilisation_wait_select = 2'h0, mode_cmd = 2'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, stab_wait_done, wdt_count_tick, wdt_clear, irq;
  logic timebase_interrupt_request, osc_running;
  logic main_stop_request, subclock_select;
  logic [3:0] buzzer_clk;
  logic [31:0] exp_q[$];
  logic [7:0] r;
  int num_errors = 0, total_checks = 0, cycles = 0, n;
  integer seed = 32'h04eb27d5;

  tbit_top i_tbit_top (.*);
  tbit_clk_model i_tbit_clk_model (.*);

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH read_data exp %h got %h", e, s);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %b got %b", nm, e, s);
    end
  endtask

  // One classic cycle, held until ack, then one idle cycle.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask

  // Read answers are compared against the oldest note.
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      chk_rd(exp_q.pop_front(), wb_dat_o);
  end

  // Cuts a hang short well past the 2^13 interval wait.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  // Main sequence of tests.
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'h28, 8'h01);
    rd(8'h30, 8'h00);
    rd(8'h00, 8'h00);
    r = 8'(($random(seed) & 8'h3e) | 8'h01);
    wb(1'b1, 8'h28, r);
    rd(8'h28, 8'h01 | (r & 8'h06));
    $display("test reset_regs done");
    wb(1'b1, 8'h30, 8'h01);
    wb(1'b1, 8'h28, 8'h00);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    chk_pin("interval", 1'b1, n > 8180 && n < 8200);
    chk_pin("tbirq_off", 1'b0, timebase_interrupt_request);
    rd(8'h28, 8'h81);
    wb(1'b1, 8'h30, 8'h00);
    chk_pin("irq_mask", 1'b0, irq);
    wb(1'b1, 8'h30, 8'h01);
    chk_pin("irq_unmask", 1'b1, irq);
    wb(1'b1, 8'h28, 8'hc1);
    chk_pin("tbirq_on", 1'b1, timebase_interrupt_request);
    wb(1'b0, 8'h2c, 8'h00);
    chk_pin("irq_rdclr", 1'b0, irq);
    wb(1'b1, 8'h28, 8'h41);
    chk_pin("tbirq_clr", 1'b0, timebase_interrupt_request);
    $display("test interval done");
    for (int m = 1; m < 3; m++) begin
      mode_cmd <= m[1:0];
      repeat (20) @(posedge ref_clk);
      chk_pin("stab_hold", 1'b0, stab_wait_done);
      chk_pin("buzz_hold", 1'b1, buzzer_clk === 4'h0);
      chk_pin("wdt_clear", 1'b1, wdt_clear);
      wdt_src_timebase <= 1'b0;
      @(posedge ref_clk);
      chk_pin("wdt_gate", 1'b0, wdt_clear);
      wdt_src_timebase <= 1'b1;
      mode_cmd <= 2'h0;
      repeat (60) @(posedge ref_clk);
      chk_pin("stab_done", 1'b1, stab_wait_done);
    end
    $display("test mode_clear done");
    // A software clear restarts the longer wait tap; bit 10 needs 4096.
    stabilisation_wait_select <= 2'h1;
    wb(1'b1, 8'h28, 8'h40);
    repeat (4000) @(posedge ref_clk);
    chk_pin("stab_early", 1'b0, stab_wait_done);
    repeat (200) @(posedge ref_clk);
    chk_pin("stab_late", 1'b1, stab_wait_done);
    // A power-on clear acts like any other counter clear.
    por_event <= 1'b1;
    @(posedge ref_clk);
    chk_pin("por_wdt", 1'b1, wdt_clear);
    por_event <= 1'b0;
    @(posedge ref_clk);
    chk_pin("por_stab", 1'b0, stab_wait_done);
    $display("test stab_por done");
    end_sim();
  end
endmodule

`default_nettype wire
